// >>> hmi_pkg.sv
// Constants and types shared by the hardware multiply instruction unit.
// How it works
// - Literal form multiplies W by an 8-bit immediate, high byte to product_high.
// - Register form multiplies W by a file register; product pair gets 16 bits.
// - No status flag changes; the 16-bit result never overflows or carries.
// - A zero product leaves the zero flag exactly as it was.
package hmi_pkg;

  localparam int OPERAND_WIDTH = 8;
  localparam int PRODUCT_WIDTH = 2 * OPERAND_WIDTH;
  localparam int INSTR_WIDTH = 16;
  localparam int BANK_WIDTH = 4;
  localparam int FILE_ADDR_WIDTH = BANK_WIDTH + OPERAND_WIDTH;

  // Literal form: opcode byte 0000 1101 followed by the literal byte.
  localparam logic [7:0] OPCODE_MUL_LITERAL = 8'h0D;
  // Register form: 0000 001a followed by the file address byte.
  localparam logic [6:0] OPCODE_MUL_REGISTER = 7'h01;

  // Field positions inside the instruction word.
  localparam int OPCODE8_MSB = 15;
  localparam int OPCODE8_LSB = 8;
  localparam int OPCODE7_LSB = 9;
  localparam int ACCESS_BIT = 8;
  localparam int OPERAND_MSB = 7;

  // Access bank: low addresses map to bank 0, the rest to the top bank.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  // Four instruction phases, Gray coded along the Q1-Q2-Q3-Q4 loop.
  typedef enum logic [1:0] {
    HMI_Q1 = 2'b00,
    HMI_Q2 = 2'b01,
    HMI_Q3 = 2'b11,
    HMI_Q4 = 2'b10
  } hmi_phase_type;

  typedef enum logic [1:0] {
    HMI_OP_NONE = 2'b00,
    HMI_OP_LITERAL = 2'b01,
    HMI_OP_REGISTER = 2'b11
  } hmi_op_type;

endpackage

// >>> hmi_mult.sv
// Unsigned combinational multiplier used by the multiply instruction unit.
`timescale 1ns/1ps
`default_nettype none
module hmi_mult #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] factor_a,
  input wire logic [WIDTH-1:0] factor_b,
  output logic [2*WIDTH-1:0] product
);

  if (WIDTH < 1) begin : g_width_check
    $error("hmi_mult: WIDTH must be at least 1");
  end

  // Both factors are zero-extended, so the full product always fits.
  always_comb begin
    product = {{WIDTH{1'b0}}, factor_a} * {{WIDTH{1'b0}}, factor_b};
  end

endmodule
`default_nettype wire

// >>> hmi_mul_unit.sv
// Execution unit for the literal and register multiply instructions.
`timescale 1ns/1ps
`default_nettype none
module hmi_mul_unit #(
  parameter int OPERAND_WIDTH = hmi_pkg::OPERAND_WIDTH,
  parameter int BANK_WIDTH = hmi_pkg::BANK_WIDTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [hmi_pkg::INSTR_WIDTH-1:0] instr_word,
  input wire logic [OPERAND_WIDTH-1:0] w_value,
  input wire logic [BANK_WIDTH-1:0] bank_select_register,
  input wire logic [OPERAND_WIDTH-1:0] file_rdata,
  input wire logic [OPERAND_WIDTH-1:0] status_in,
  output logic [1:0] q_phase,
  output logic file_rd_en,
  output logic [BANK_WIDTH+OPERAND_WIDTH-1:0] file_addr,
  output logic [OPERAND_WIDTH-1:0] product_high,
  output logic [OPERAND_WIDTH-1:0] product_low,
  output logic product_we,
  output logic [OPERAND_WIDTH-1:0] status_out,
  output logic instr_unknown
);

  // The opcode layout and access bank mapping are fixed at byte operands
  // and a four-bit bank number, so other widths are refused.
  if (OPERAND_WIDTH != hmi_pkg::OPERAND_WIDTH || BANK_WIDTH != hmi_pkg::BANK_WIDTH) begin : g_param_check
    $error("hmi_mul_unit: operand and bank widths must match the instruction encoding");
  end

  typedef struct packed {
    hmi_pkg::hmi_phase_type phase;
    hmi_pkg::hmi_op_type op;
    logic [hmi_pkg::INSTR_WIDTH-1:0] instr;
    logic [OPERAND_WIDTH-1:0] op_a;
    logic [OPERAND_WIDTH-1:0] op_b;
    logic rd_en;
    logic [BANK_WIDTH+OPERAND_WIDTH-1:0] addr;
    logic [OPERAND_WIDTH-1:0] prod_high;
    logic [OPERAND_WIDTH-1:0] prod_low;
    logic prod_we;
    logic [OPERAND_WIDTH-1:0] status;
    logic unknown;
  } hmi_state_type;

  hmi_state_type state;
  hmi_state_type next_state;
  logic [2*OPERAND_WIDTH-1:0] mult_result;
  logic [7:0] opcode8;
  logic [6:0] opcode7;
  logic [OPERAND_WIDTH-1:0] operand_field;
  logic access_sel;

  hmi_mult #(
    .WIDTH(OPERAND_WIDTH)
  ) u_mult (
    .factor_a(state.op_a),
    .factor_b(state.op_b),
    .product(mult_result)
  );

  always_comb begin
    opcode8 = state.instr[hmi_pkg::OPCODE8_MSB:hmi_pkg::OPCODE8_LSB];
    opcode7 = state.instr[hmi_pkg::OPCODE8_MSB:hmi_pkg::OPCODE7_LSB];
    operand_field = state.instr[hmi_pkg::OPERAND_MSB:0];
    access_sel = state.instr[hmi_pkg::ACCESS_BIT];
  end

  always_comb begin
    next_state = state;
    // Strobes last one cycle unless a phase raises them again.
    next_state.rd_en = 1'b0;
    next_state.prod_we = 1'b0;
    next_state.unknown = 1'b0;
    case (state.phase)
      hmi_pkg::HMI_Q1: begin
        // Decode phase: take the instruction word and the W operand.
        next_state.phase = hmi_pkg::HMI_Q2;
        next_state.op = hmi_pkg::HMI_OP_NONE;
        if (instr_valid) begin
          next_state.instr = instr_word;
          next_state.op_a = w_value;
          // Flags are captured untouched; the multiply never rewrites them.
          next_state.status = status_in;
          if (instr_word[hmi_pkg::OPCODE8_MSB:hmi_pkg::OPCODE8_LSB] == hmi_pkg::OPCODE_MUL_LITERAL) begin
            next_state.op = hmi_pkg::HMI_OP_LITERAL;
          end else if (instr_word[hmi_pkg::OPCODE8_MSB:hmi_pkg::OPCODE7_LSB] == hmi_pkg::OPCODE_MUL_REGISTER) begin
            next_state.op = hmi_pkg::HMI_OP_REGISTER;
          end else begin
            next_state.unknown = 1'b1;
          end
        end
      end
      hmi_pkg::HMI_Q2: begin
        // Read phase: the literal comes from the word, a file register is fetched.
        next_state.phase = hmi_pkg::HMI_Q3;
        if (state.op == hmi_pkg::HMI_OP_LITERAL && opcode8 == hmi_pkg::OPCODE_MUL_LITERAL) begin
          next_state.op_b = operand_field;
        end else if (state.op == hmi_pkg::HMI_OP_REGISTER && opcode7 == hmi_pkg::OPCODE_MUL_REGISTER) begin
          next_state.rd_en = 1'b1;
          if (access_sel) begin
            next_state.addr = {bank_select_register, operand_field};
          end else if (operand_field < hmi_pkg::ACCESS_SPLIT) begin
            next_state.addr = {hmi_pkg::ACCESS_LOW_BANK, operand_field};
          end else begin
            next_state.addr = {hmi_pkg::ACCESS_HIGH_BANK, operand_field};
          end
        end
      end
      hmi_pkg::HMI_Q3: begin
        // Process phase: the file register answers in the same cycle as the read strobe.
        next_state.phase = hmi_pkg::HMI_Q4;
        if (state.op == hmi_pkg::HMI_OP_REGISTER) begin
          next_state.op_b = file_rdata;
        end
      end
      hmi_pkg::HMI_Q4: begin
        // Write phase: only the product pair is written; W and the file
        // register have no write path here, so both sources stay intact.
        next_state.phase = hmi_pkg::HMI_Q1;
        if (state.op != hmi_pkg::HMI_OP_NONE) begin
          next_state.prod_high = mult_result[2*OPERAND_WIDTH-1:OPERAND_WIDTH];
          next_state.prod_low = mult_result[OPERAND_WIDTH-1:0];
          next_state.prod_we = 1'b1;
        end
        // A zero product is deliberately not tested; the flags go back as taken.
        next_state.status = state.status;
      end
      default: begin
        next_state.phase = hmi_pkg::HMI_Q1;
        next_state.op = hmi_pkg::HMI_OP_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state.phase <= hmi_pkg::HMI_Q1;
      state.op <= hmi_pkg::HMI_OP_NONE;
      state.instr <= hmi_pkg::INSTR_RESET;
      state.op_a <= hmi_pkg::BYTE_RESET;
      state.op_b <= hmi_pkg::BYTE_RESET;
      state.rd_en <= 1'b0;
      state.addr <= hmi_pkg::ADDR_RESET;
      state.prod_high <= hmi_pkg::BYTE_RESET;
      state.prod_low <= hmi_pkg::BYTE_RESET;
      state.prod_we <= 1'b0;
      state.status <= hmi_pkg::BYTE_RESET;
      state.unknown <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    q_phase = state.phase;
    file_rd_en = state.rd_en;
    file_addr = state.addr;
    product_high = state.prod_high;
    product_low = state.prod_low;
    product_we = state.prod_we;
    status_out = state.status;
    instr_unknown = state.unknown;
  end

endmodule
`default_nettype wire

// >>> hmi_mul_unit_monitor.sv
// Port-level assertions for the multiply instruction unit.
`timescale 1ns/1ps
`default_nettype none
module hmi_mul_unit_monitor #(
  parameter int OPERAND_WIDTH = 8,
  parameter int BANK_WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [hmi_pkg::INSTR_WIDTH-1:0] instr_word,
  input wire logic [OPERAND_WIDTH-1:0] w_value,
  input wire logic [BANK_WIDTH-1:0] bank_select_register,
  input wire logic [OPERAND_WIDTH-1:0] file_rdata,
  input wire logic [OPERAND_WIDTH-1:0] status_in,
  input wire logic [1:0] q_phase,
  input wire logic file_rd_en,
  input wire logic [BANK_WIDTH+OPERAND_WIDTH-1:0] file_addr,
  input wire logic [OPERAND_WIDTH-1:0] product_high,
  input wire logic [OPERAND_WIDTH-1:0] product_low,
  input wire logic product_we,
  input wire logic [OPERAND_WIDTH-1:0] status_out,
  input wire logic instr_unknown
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire take = instr_valid && q_phase == 2'h0;
  sequence s_lit;
    take && instr_word[15:8] == 8'h0D;
  endsequence
  sequence s_reg;
    take && instr_word[15:9] == 7'h01;
  endsequence
  property p_lit;
    logic [7:0] w, k;
    (s_lit, w = w_value, k = instr_word[7:0]) |-> ##4 product_we && {product_high, product_low} == 16'(w) * 16'(k);
  endproperty
  property p_reg;
    logic [7:0] w, d;
    (s_reg, w = w_value) ##2 (file_rd_en, d = file_rdata) |-> ##2 product_we
      && {product_high, product_low} == 16'(w) * 16'(d);
  endproperty
  property p_addr;
    logic [7:0] f;
    logic a;
    logic [BANK_WIDTH-1:0] b;
    (s_reg, f = instr_word[7:0], a = instr_word[8]) ##1 (1'b1, b = bank_select_register) |-> ##1 file_rd_en
      && file_addr == (a ? {b, f} : {(f < 8'h60) ? 4'h0 : 4'hF, f});
  endproperty
  a_lit_product: assert property (p_lit) else $error("literal product wrong");
  a_reg_product: assert property (p_reg) else $error("register product wrong");
  a_file_address: assert property (p_addr) else $error("file address wrong");
  a_status_take: assert property (take |=> status_out == $past(status_in)) else $error("status altered");
  a_status_hold: assert property (!take |=> $stable(status_out)) else $error("status changed");
  a_phase_loop: assert property (q_phase == 2'h0 |=> q_phase == 2'h1 ##1 q_phase == 2'h3 ##1 q_phase == 2'h2)
    else $error("phase order wrong");
  a_we_pulse: assert property (product_we |=> !product_we [*3]) else $error("write pulse repeats");
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the multiply instruction unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] w_value = 8'h00, file_rdata = 8'h00, status_in = 8'h00, product_high, product_low, status_out;
  logic [3:0] bank_select_register = 4'h5;
  logic [1:0] q_phase;
  logic file_rd_en, product_we, instr_unknown;
  logic [11:0] file_addr;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  hmi_mul_unit dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .w_value(w_value), .bank_select_register(bank_select_register), .file_rdata(file_rdata), .status_in(status_in),
    .q_phase(q_phase), .file_rd_en(file_rd_en), .file_addr(file_addr), .product_high(product_high),
    .product_low(product_low), .product_we(product_we), .status_out(status_out), .instr_unknown(instr_unknown));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The run should take about 70 cycles, so 1000 means a hang.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Drives in the Q1 it is called in and returns in the Q1 after Q4, so consecutive calls run back to back.
  task automatic do_op(input logic [15:0] word, input logic [7:0] w, d, st, input logic [11:0] addr, input logic rg, mul);
    int i;
    for (i = 0; i < 4 && q_phase !== 2'h0; i++) @(negedge sys_clk);
    instr_word = word;
    w_value = w;
    file_rdata = d;
    status_in = st;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    check("unknown", {15'h0, instr_unknown}, {15'h0, !mul});
    @(negedge sys_clk);
    check("phase", {14'h0, q_phase}, 16'h0003);
    check("file_rd", {15'h0, file_rd_en}, {15'h0, rg});
    if (rg) check("file_addr", {3'h0, file_rd_en, file_addr}, {4'h1, addr});
    repeat (2) @(negedge sys_clk);
    check("we", {15'h0, product_we}, {15'h0, mul});
    if (mul) check("product", {product_high, product_low}, 16'(w) * 16'(rg ? d : word[7:0]));
    check("status", {8'h0, status_out}, {8'h0, st});
  endtask
  task automatic t_literal();
    do_op(16'h0DC4, 8'hE2, 8'h77, 8'h5A, 12'h000, 1'b0, 1'b1);
    do_op(16'h0D00, 8'h00, 8'h00, 8'h00, 12'h000, 1'b0, 1'b1);
    do_op(16'h0DFF, 8'hFF, 8'h00, 8'hFF, 12'h000, 1'b0, 1'b1);
  endtask
  task automatic t_register();
    do_op(16'h0333, 8'hC4, 8'hB5, 8'h11, 12'h533, 1'b1, 1'b1);
    do_op(16'h025F, 8'h10, 8'h80, 8'h04, 12'h05F, 1'b1, 1'b1);
    do_op(16'h0260, 8'h03, 8'hFF, 8'h00, 12'hF60, 1'b1, 1'b1);
    bank_select_register = 4'hA;
    do_op(16'h03F0, 8'h7F, 8'h81, 8'hA5, 12'hAF0, 1'b1, 1'b1);
  endtask
  task automatic t_unknown();
    do_op(16'h0E12, 8'h22, 8'h00, 8'h3C, 12'h000, 1'b0, 1'b0);
  endtask
  // A valid multiply word outside the decode phase must be ignored.
  task automatic t_refused();
    @(negedge sys_clk);
    instr_word = 16'h0D55;
    w_value = 8'h33;
    instr_valid = 1'b1;
    repeat (3) @(negedge sys_clk);
    instr_valid = 1'b0;
    repeat (4) begin
      @(negedge sys_clk);
      check("refused we", {15'h0, product_we}, 16'h0000);
    end
  endtask
  // Reset in mid-instruction clears every output, and a word may follow at once.
  task automatic t_reset();
    instr_word = 16'h0D33;
    w_value = 8'h11;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    sys_rst = 1'b1;
    @(negedge sys_clk);
    check("reset product", {product_high, product_low}, 16'h0000);
    check("reset flags", {status_out, q_phase, file_rd_en, product_we, instr_unknown, 3'h0}, 16'h0000);
    check("reset addr", {4'h0, file_addr}, 16'h0000);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    do_op(16'h0D02, 8'h80, 8'h00, 8'hC3, 12'h000, 1'b0, 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    t_literal();
    t_register();
    t_unknown();
    t_refused();
    t_reset();
    stop_test();
  end
endmodule
bind hmi_mul_unit hmi_mul_unit_monitor #(.OPERAND_WIDTH(OPERAND_WIDTH), .BANK_WIDTH(BANK_WIDTH)) mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word), .w_value(w_value),
  .bank_select_register(bank_select_register), .file_rdata(file_rdata), .status_in(status_in), .q_phase(q_phase),
  .file_rd_en(file_rd_en), .file_addr(file_addr), .product_high(product_high), .product_low(product_low),
  .product_we(product_we), .status_out(status_out), .instr_unknown(instr_unknown));
`default_nettype wire
